// >>> hdl/alarm_thresh_pkg.sv
// Constants and carriers for the supply and bias alarm threshold bank
// How it works
// - High-voltage alarm sets when supply upper byte exceeds high threshold upper.
// - Low-voltage alarm sets when supply upper byte is below low threshold upper.
// - High-bias alarm sets when bias upper byte exceeds bias threshold upper.
// - Lower threshold bytes are plain storage, never used in comparisons.
// - Voltage threshold upper byte counts 25.6mV, compared directly with measurement.
// - Voltage threshold lower byte extends to sixteen bits, 100uV per count.
// - Bias threshold lower byte extends to sixteen bits, 2uA per count.
// - Comparisons use raw uncalibrated measurements, no calibration either side.
package alarm_thresh_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] VOLT_HI_UPPER_OFS = 8'h08;
  localparam logic [7:0] VOLT_HI_LOWER_OFS = 8'h09;
  localparam logic [7:0] VOLT_LO_UPPER_OFS = 8'h0A;
  localparam logic [7:0] VOLT_LO_LOWER_OFS = 8'h0B;
  localparam logic [7:0] BIAS_HI_UPPER_OFS = 8'h10;
  localparam logic [7:0] BIAS_HI_LOWER_OFS = 8'h11;

  localparam logic [7:0] THRESH_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Scale of each byte except the bias upper byte, in microvolts or microamperes per count
  localparam real VOLT_UPPER_UV_PER_LSB = 25600.0;
  localparam real VOLT_LOWER_UV_PER_LSB = 100.0;
  localparam real BIAS_LOWER_UA_PER_LSB = 2.0;

  localparam int unsigned FLAG_VOLT_HI = 0;
  localparam int unsigned FLAG_VOLT_LO = 1;
  localparam int unsigned FLAG_BIAS_HI = 2;
  localparam int unsigned NUM_FLAGS    = 3;

  typedef struct packed {
    logic [7:0] volt_hi_thresh_upper;
    logic [7:0] volt_hi_thresh_lower;
    logic [7:0] volt_lo_thresh_upper;
    logic [7:0] volt_lo_thresh_lower;
    logic [7:0] bias_hi_thresh_upper;
    logic [7:0] bias_hi_thresh_lower;
  } thresh_bank_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] supply_meas_upper;
    logic [7:0] supply_meas_lower;
  } supply_meas_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] bias_meas_upper;
    logic [7:0] bias_meas_lower;
  } bias_meas_t;

endpackage

// >>> hdl/upper_byte_compare.sv
// Upper-byte threshold comparator with re-evaluation strobe
`timescale 1ns/1ps
`default_nettype none
module upper_byte_compare #(
  parameter bit GREATER = 1'b1
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       ce_in,
  input  wire logic       load_in,
  input  wire logic [7:0] meas_upper_in,
  input  wire logic [7:0] thresh_upper_in,
  output var  logic       alarm_flag_out
);

  typedef struct packed {
    logic alarm_flag;
  } cmp_state_t;

  cmp_state_t state_reg;
  cmp_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (load_in) begin
      // Strict compare on upper bytes only; raw values, no calibration
      if (GREATER) begin
        state_next.alarm_flag = meas_upper_in > thresh_upper_in;
      end else begin
        state_next.alarm_flag = meas_upper_in < thresh_upper_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  assign alarm_flag_out = state_reg.alarm_flag;

endmodule
`default_nettype wire

// >>> hdl/alarm_thresh_bank.sv
// Supply and bias alarm threshold registers with comparison flags
`timescale 1ns/1ps
`default_nettype none
module alarm_thresh_bank
  import alarm_thresh_pkg::*;
(
  input  wire logic         CLK_IN,
  input  wire logic         RST_N_IN,
  input  wire logic         CE_IN,
  input  wire reg_req_t     REG_REQ_IN,
  input  wire supply_meas_t SUPPLY_MEAS_IN,
  input  wire bias_meas_t   BIAS_MEAS_IN,
  output var  logic [7:0]   RDATA_OUT,
  output var  logic         RVALID_OUT,
  output var  logic         VOLT_HI_ALARM_OUT,
  output var  logic         VOLT_LO_ALARM_OUT,
  output var  logic         BIAS_HI_ALARM_OUT
);

  typedef struct packed {
    thresh_bank_t bank;
    logic [7:0]   rdata;
    logic         rvalid;
  } bank_state_t;

  bank_state_t state_reg;
  bank_state_t state_next;
  logic [NUM_FLAGS-1:0] flag_w;

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode, shared by read path
  function automatic logic [7:0] read_mux(input thresh_bank_t b,
                                          input logic [7:0]   a);
    logic [7:0] r;
    r = UNMAPPED_READ;
    unique case (a)
      VOLT_HI_UPPER_OFS: r = b.volt_hi_thresh_upper;
      VOLT_HI_LOWER_OFS: r = b.volt_hi_thresh_lower;
      VOLT_LO_UPPER_OFS: r = b.volt_lo_thresh_upper;
      VOLT_LO_LOWER_OFS: r = b.volt_lo_thresh_lower;
      BIAS_HI_UPPER_OFS: r = b.bias_hi_thresh_upper;
      BIAS_HI_LOWER_OFS: r = b.bias_hi_thresh_lower;
      default:           r = UNMAPPED_READ;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file: byte writes, one-cycle registered read
  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = REG_REQ_IN.rd;
    if (REG_REQ_IN.rd) begin
      state_next.rdata = read_mux(state_reg.bank, REG_REQ_IN.addr);
    end
    if (REG_REQ_IN.wr) begin
      unique case (REG_REQ_IN.addr)
        // Upper bytes: voltage ones 25.6mV per count, all three fed to the comparators
        VOLT_HI_UPPER_OFS:
          state_next.bank.volt_hi_thresh_upper = REG_REQ_IN.wdata;
        VOLT_LO_UPPER_OFS:
          state_next.bank.volt_lo_thresh_upper = REG_REQ_IN.wdata;
        BIAS_HI_UPPER_OFS:
          state_next.bank.bias_hi_thresh_upper = REG_REQ_IN.wdata;
        // Lower bytes are storage only; nonzero values are kept as written
        VOLT_HI_LOWER_OFS:
          state_next.bank.volt_hi_thresh_lower = REG_REQ_IN.wdata;
        VOLT_LO_LOWER_OFS:
          state_next.bank.volt_lo_thresh_lower = REG_REQ_IN.wdata;
        BIAS_HI_LOWER_OFS:
          state_next.bank.bias_hi_thresh_lower = REG_REQ_IN.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg.bank   <= {6{THRESH_RESET}};
      state_reg.rdata  <= UNMAPPED_READ;
      state_reg.rvalid <= 1'b0;
    end else if (CE_IN) begin
      state_reg <= state_next;
    end
  end

  assign RDATA_OUT  = state_reg.rdata;
  assign RVALID_OUT = state_reg.rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Comparators: upper bytes only, lower bytes never reach them
  upper_byte_compare #(.GREATER(1'b1)) u_volt_hi (
    .clk_in          (CLK_IN),
    .rst_n_in        (RST_N_IN),
    .ce_in           (CE_IN),
    .load_in         (SUPPLY_MEAS_IN.valid),
    .meas_upper_in   (SUPPLY_MEAS_IN.supply_meas_upper),
    .thresh_upper_in (state_reg.bank.volt_hi_thresh_upper),
    .alarm_flag_out  (flag_w[FLAG_VOLT_HI])
  );

  upper_byte_compare #(.GREATER(1'b0)) u_volt_lo (
    .clk_in          (CLK_IN),
    .rst_n_in        (RST_N_IN),
    .ce_in           (CE_IN),
    .load_in         (SUPPLY_MEAS_IN.valid),
    .meas_upper_in   (SUPPLY_MEAS_IN.supply_meas_upper),
    .thresh_upper_in (state_reg.bank.volt_lo_thresh_upper),
    .alarm_flag_out  (flag_w[FLAG_VOLT_LO])
  );

  upper_byte_compare #(.GREATER(1'b1)) u_bias_hi (
    .clk_in          (CLK_IN),
    .rst_n_in        (RST_N_IN),
    .ce_in           (CE_IN),
    .load_in         (BIAS_MEAS_IN.valid),
    .meas_upper_in   (BIAS_MEAS_IN.bias_meas_upper),
    .thresh_upper_in (state_reg.bank.bias_hi_thresh_upper),
    .alarm_flag_out  (flag_w[FLAG_BIAS_HI])
  );

  assign VOLT_HI_ALARM_OUT = flag_w[FLAG_VOLT_HI];
  assign VOLT_LO_ALARM_OUT = flag_w[FLAG_VOLT_LO];
  assign BIAS_HI_ALARM_OUT = flag_w[FLAG_BIAS_HI];

endmodule
`default_nettype wire

// >>> verif/alarm_thresh_bank_asserts.sv
// Port-level assertions for the alarm threshold bank
`timescale 1ns/1ps
`default_nettype none
module alarm_thresh_bank_asserts
  import alarm_thresh_pkg::*;
(
  input wire logic         CLK_IN,
  input wire logic         RST_N_IN,
  input wire logic         CE_IN,
  input wire reg_req_t     REG_REQ_IN,
  input wire supply_meas_t SUPPLY_MEAS_IN,
  input wire bias_meas_t   BIAS_MEAS_IN,
  input wire logic [7:0]   RDATA_OUT,
  input wire logic         RVALID_OUT,
  input wire logic         VOLT_HI_ALARM_OUT,
  input wire logic         VOLT_LO_ALARM_OUT,
  input wire logic         BIAS_HI_ALARM_OUT
);
  logic [7:0] sh [0:255];
  logic [7:0] exp_rd;
  logic       exp_vh, exp_vl, exp_bh, rd_tk, s_tk, b_tk;
  assign rd_tk = CE_IN && REG_REQ_IN.rd;
  assign s_tk  = CE_IN && SUPPLY_MEAS_IN.valid;
  assign b_tk  = CE_IN && BIAS_MEAS_IN.valid;
  // Shadow of the bank; unmapped bytes stay zero
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sh     <= '{default: 8'h00};
      exp_rd <= 8'h00;
      exp_vh <= 1'b0;
      exp_vl <= 1'b0;
      exp_bh <= 1'b0;
    end else if (CE_IN) begin
      if (REG_REQ_IN.wr && REG_REQ_IN.addr inside
          {VOLT_HI_UPPER_OFS, VOLT_HI_LOWER_OFS, VOLT_LO_UPPER_OFS,
           VOLT_LO_LOWER_OFS, BIAS_HI_UPPER_OFS, BIAS_HI_LOWER_OFS})
        sh[REG_REQ_IN.addr] <= REG_REQ_IN.wdata;
      exp_rd <= sh[REG_REQ_IN.addr];
      exp_vh <= SUPPLY_MEAS_IN.supply_meas_upper > sh[VOLT_HI_UPPER_OFS];
      exp_vl <= SUPPLY_MEAS_IN.supply_meas_upper < sh[VOLT_LO_UPPER_OFS];
      exp_bh <= BIAS_MEAS_IN.bias_meas_upper > sh[BIAS_HI_UPPER_OFS];
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence rd_answer;
    ##1 RVALID_OUT && RDATA_OUT == exp_rd;
  endsequence
  rd_answer_a: assert property (rd_tk |-> rd_answer)
    else $error("read answer wrong");
  // A frozen enable keeps the valid pulse up, so only enabled edges count
  rvalid_cause_a: assert property (RVALID_OUT && $past(CE_IN) |->
    $past(REG_REQ_IN.rd)) else $error("read valid without read");
  rdata_hold_a: assert property (!rd_tk |=> $stable(RDATA_OUT))
    else $error("read data moved");
  volt_hi_a: assert property (s_tk |=> VOLT_HI_ALARM_OUT == exp_vh)
    else $error("high voltage alarm wrong");
  volt_lo_a: assert property (s_tk |=> VOLT_LO_ALARM_OUT == exp_vl)
    else $error("low voltage alarm wrong");
  bias_hi_a: assert property (b_tk |=> BIAS_HI_ALARM_OUT == exp_bh)
    else $error("high bias alarm wrong");
  volt_hold_a: assert property (!s_tk |=> $stable(VOLT_LO_ALARM_OUT)
    && $stable(VOLT_HI_ALARM_OUT)) else $error("voltage alarm moved");
  bias_hold_a: assert property (!b_tk |=> $stable(BIAS_HI_ALARM_OUT))
    else $error("bias alarm moved");
endmodule
bind alarm_thresh_bank alarm_thresh_bank_asserts u_chk (.CLK_IN, .RST_N_IN,
  .CE_IN, .REG_REQ_IN, .SUPPLY_MEAS_IN, .BIAS_MEAS_IN, .RDATA_OUT,
  .RVALID_OUT, .VOLT_HI_ALARM_OUT, .VOLT_LO_ALARM_OUT, .BIAS_HI_ALARM_OUT);
`default_nettype wire

// >>> verif/host_ctrl_model.sv
// Host controller model on the byte register port
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model
  import alarm_thresh_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rvalid_in,
  input  wire logic [7:0] rdata_in,
  output var  reg_req_t   req_out
);
  initial req_out = '0;
  // Lower bytes may be written nonzero, as a host is free to
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q, output logic ok);
    @(posedge clk_in);
    req_out <= '{w, !w, a, d};
    @(posedge clk_in);
    // Released lines show inverted values, not the last ones
    req_out <= '{1'b0, 1'b0, ~a, ~d};
    #1;
    ok = w | rvalid_in;
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

// >>> verif/alarm_thresh_bank_tb_top.sv
// Self-checking bench for the alarm threshold bank
`timescale 1ns/1ps
`default_nettype none
module alarm_thresh_bank_tb_top;
  import alarm_thresh_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, rvalid, vhi, vlo, bhi;
  logic [7:0] rdata;
  reg_req_t req;
  supply_meas_t sup = '0;
  bias_meas_t bias = '0;
  int n_fail = 0, n_compared = 0;
  always #25 clk = ~clk;
  alarm_thresh_bank u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
    .REG_REQ_IN(req), .SUPPLY_MEAS_IN(sup), .BIAS_MEAS_IN(bias),
    .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .VOLT_HI_ALARM_OUT(vhi),
    .VOLT_LO_ALARM_OUT(vlo), .BIAS_HI_ALARM_OUT(bhi));
  host_ctrl_model u_host (.clk_in(clk), .rvalid_in(rvalid),
    .rdata_in(rdata), .req_out(req));
  task automatic chk(input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rw(input logic w, input logic [7:0] a, d);
    logic [7:0] q;
    logic ok;
    u_host.xfer(w, a, d, q, ok);
    chk({7'h00, ok}, 8'h01);
    if (!w) chk(q, d);
  endtask
  // Lower measurement bytes are all ones: a 16-bit compare would differ
  task automatic meas(input logic [7:0] su, bu, input logic [2:0] e);
    @(posedge clk);
    sup <= '{1'b1, su, 8'hFF};
    bias <= '{1'b1, bu, 8'hFF};
    @(posedge clk);
    sup.valid <= 1'b0;
    bias.valid <= 1'b0;
    #1;
    chk({5'h00, bhi, vlo, vhi}, {5'h00, e});
  endtask
  task automatic t_regs;
    logic [7:0] m [7] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h10, 8'h11, 8'h0C};
    foreach (m[i]) rw(1'b0, m[i], 8'h00);
    foreach (m[i]) rw(1'b1, m[i], m[i] ^ 8'hA5);
    foreach (m[i]) rw(1'b0, m[i], i == 6 ? 8'h00 : m[i] ^ 8'hA5);
  endtask
  task automatic t_compare;
    rw(1'b1, 8'h08, 8'h80);
    rw(1'b1, 8'h09, 8'h00);
    rw(1'b1, 8'h0A, 8'h40);
    rw(1'b1, 8'h0B, 8'hFF);
    rw(1'b1, 8'h10, 8'h20);
    rw(1'b1, 8'h11, 8'h00);
    meas(8'h80, 8'h20, 3'b000);
    meas(8'h3F, 8'hFF, 3'b110);
    meas(8'h40, 8'h00, 3'b000);
    meas(8'h81, 8'h21, 3'b101);
  endtask
  task automatic t_hold;
    rw(1'b1, 8'h08, 8'hFF);
    rw(1'b1, 8'h10, 8'hFF);
    chk({5'h00, bhi, vlo, vhi}, 8'h05);
    // Frozen enable: neither the write nor the measurement may land
    @(posedge clk);
    ce <= 1'b0;
    rw(1'b1, 8'h0A, 8'h00);
    meas(8'h00, 8'h00, 3'b101);
    @(posedge clk);
    ce <= 1'b1;
    rw(1'b0, 8'h0A, 8'h40);
    meas(8'h00, 8'h00, 3'b010);
  endtask
  // Mid-run reset clears thresholds, read port and alarms
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    chk({5'h00, bhi, vlo, vhi}, 8'h00);
    chk({7'h00, rvalid}, 8'h00);
    chk(rdata, 8'h00);
    rst_n <= 1'b1;
    rw(1'b0, 8'h08, 8'h00);
    rw(1'b0, 8'h10, 8'h00);
    meas(8'h01, 8'h01, 3'b101);
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_compare();
    t_hold();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
